// ==== design/liu_tx_pkg.sv ====
// Shared constants and types for the transmit front end and its feeding controller.
package liu_tx_pkg;

  // Device register offsets on the host control port.
  localparam logic [7:0] OFF_TX_CONFIG_0 = 8'h02;
  localparam logic [7:0] OFF_TX_PULSE_SELECT = 8'h03;
  localparam logic [7:0] OFF_TX_AMPLITUDE_SCALE = 8'h04;
  localparam logic [7:0] OFF_WAVEFORM_RAM_CONTROL = 8'h05;
  localparam logic [7:0] OFF_WAVEFORM_RAM_DATA = 8'h06;
  localparam logic [7:0] OFF_INTERRUPT_MASK_1 = 8'h12;
  localparam logic [7:0] OFF_INTERRUPT_STATUS_1 = 8'h17;
  localparam logic [7:0] OFF_GLOBAL_CONFIG = 8'h40;

  // Field positions in tx_config_0, waveform_ram_control, the interrupt registers and the global configuration register.
  localparam int CFG_ENCODER_BIT = 0;
  localparam int CFG_RAIL_BIT = 1;
  localparam int CFG_EDGE_BIT = 2;
  localparam int CFG_INVERT_BIT = 3;
  localparam int RAM_DIR_BIT = 6;
  localparam int RAM_EXEC_BIT = 7;
  localparam int INT_CLOCK_LOSS_BIT = 0;
  localparam int INT_OVERFLOW_BIT = 1;
  localparam int GCFG_STANDARD_BIT = 0;

  // Reset values and waveform limits.
  localparam logic [5:0] SCALE_DEFAULT = 6'h21;
  localparam logic [1:0] PULSE_ARB_PREFIX = 2'h3;
  localparam int SAMPLE_MAX = 63;
  localparam int UI_COUNT = 4;
  localparam int PHASE_COUNT = 16;
  localparam int RAM_WORDS = UI_COUNT * PHASE_COUNT;
  localparam logic [3:0] PHASE_LAST = 4'hf;
  localparam logic [3:0] TEMPLATE_FIRST = 4'h4;
  localparam logic [3:0] TEMPLATE_LAST = 4'hb;
  localparam logic [6:0] CLOCK_LOSS_CYCLES = 7'h46;
  localparam int ENC_DEPTH = 8;

  // Flat-top peak of each of the twelve ROM templates, in pulse_select order.
  localparam logic [6:0] TEMPLATE_PEAK [12] = '{7'h30, 7'h30, 7'h27, 7'h2e, 7'h34, 7'h3b,
    7'h3f, 7'h2c, 7'h3c, 7'h1a, 7'h0b, 7'h05};

  // Link clock rates and the half-period divisors derived from pclk.
  localparam int PCLK_HZ = 40000000;
  localparam int E1_RATE_HZ = 2048000;
  localparam int T1_RATE_HZ = 1544000;
  localparam logic [4:0] E1_HALF = 5'(PCLK_HZ / (2 * E1_RATE_HZ));
  localparam logic [4:0] T1_HALF = 5'(PCLK_HZ / (2 * T1_RATE_HZ));
  localparam int LINK_BITS = 8;

  // Controller registers on APB.
  localparam logic [7:0] OFF_HOST_CONTROL = 8'h00;
  localparam logic [7:0] OFF_HOST_DATA = 8'h04;
  localparam logic [7:0] OFF_HOST_STATUS = 8'h08;
  localparam int HCTL_ENABLE_BIT = 0;
  localparam int HCTL_T1_BIT = 1;
  localparam int HCTL_DUAL_BIT = 2;
  localparam int HCTL_RISE_BIT = 3;
  localparam int HCTL_INVERT_BIT = 4;

  // Line symbol codes held in the encoder delay line.
  typedef enum logic [1:0] {SYM_SPACE, SYM_MARK, SYM_VIOL} sym_t;

endpackage

// ==== design/liu_tx_link_if.sv ====
// Transmit system link between the framer-side controller and the line interface.
`timescale 1ns/1ps
`default_nettype none
interface liu_tx_link_if;
  logic tx_line_clock; // Transmit clock made by the controller.
  logic tx_pos_rail_in; // Single rail data, or positive rail in dual rail.
  logic tx_neg_rail_in; // Negative rail in dual rail.

  modport device (input tx_line_clock, input tx_pos_rail_in, input tx_neg_rail_in);
  modport host (output tx_line_clock, output tx_pos_rail_in, output tx_neg_rail_in);
endinterface
`default_nettype wire

// ==== design/liu_line_encoder.sv ====
// Single rail line encoder: AMI with optional B8ZS or HDB3 zero substitution.
`timescale 1ns/1ps
`default_nettype none
module liu_line_encoder (
  input wire logic pclk, // Master clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic strobe, // One bit period tick.
  input wire logic bit_in, // Data bit taken on strobe.
  input wire logic substitute, // 1 selects B8ZS or HDB3, 0 plain AMI.
  input wire logic t1_mode, // 1 for T1/J1, 0 for E1.
  output logic pulse_pos, // Positive line pulse for this bit period.
  output logic pulse_neg // Negative line pulse for this bit period.
);
  liu_tx_pkg::sym_t codes [liu_tx_pkg::ENC_DEPTH];
  liu_tx_pkg::sym_t next_codes [liu_tx_pkg::ENC_DEPTH];
  logic ones_odd;
  logic next_ones_odd;
  logic last_pos;

  // True when the given number of newest slots are all spaces.
  function automatic logic newest_spaces(input liu_tx_pkg::sym_t c [liu_tx_pkg::ENC_DEPTH],
                                         input int n);
    logic all_space;
    all_space = 1'b1;
    for (int i = 0; i < liu_tx_pkg::ENC_DEPTH; i++)
    begin
      if (i < n && c[i] != liu_tx_pkg::SYM_SPACE)
        all_space = 1'b0;
    end
    return all_space;
  endfunction

  // Shift the new bit in, then apply the zero substitution that the mode asks for.
  always_comb
  begin
    next_codes[0] = bit_in ? liu_tx_pkg::SYM_MARK : liu_tx_pkg::SYM_SPACE;
    for (int i = 1; i < liu_tx_pkg::ENC_DEPTH; i++)
      next_codes[i] = codes[i-1];
    next_ones_odd = ones_odd ^ bit_in;
    if (substitute && t1_mode && newest_spaces(next_codes, 8)) // R07
    begin
      next_codes[4] = liu_tx_pkg::SYM_VIOL;
      next_codes[3] = liu_tx_pkg::SYM_MARK;
      next_codes[1] = liu_tx_pkg::SYM_VIOL;
      next_codes[0] = liu_tx_pkg::SYM_MARK;
    end
    else if (substitute && !t1_mode && newest_spaces(next_codes, 4)) // R08
    begin
      if (!ones_odd)
        next_codes[3] = liu_tx_pkg::SYM_MARK;
      next_codes[0] = liu_tx_pkg::SYM_VIOL;
      next_ones_odd = 1'b0;
    end
  end

  // Delay line and mark parity advance once per bit period.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < liu_tx_pkg::ENC_DEPTH; i++)
        codes[i] <= liu_tx_pkg::SYM_SPACE;
      ones_odd <= 1'b0;
    end
    else if (strobe)
    begin
      codes <= next_codes;
      ones_odd <= next_ones_odd;
    end
  end

  // The oldest slot leaves as a pulse; a mark alternates, a violation repeats polarity.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_pos <= 1'b0;
      pulse_pos <= 1'b0;
      pulse_neg <= 1'b0;
    end
    else if (strobe)
    begin
      case (codes[liu_tx_pkg::ENC_DEPTH-1])
        liu_tx_pkg::SYM_MARK:
        begin
          last_pos <= !last_pos;
          pulse_pos <= !last_pos;
          pulse_neg <= last_pos;
        end
        liu_tx_pkg::SYM_VIOL:
        begin
          pulse_pos <= last_pos;
          pulse_neg <= !last_pos;
        end
        default:
        begin
          pulse_pos <= 1'b0;
          pulse_neg <= 1'b0;
        end
      endcase
    end
  end
endmodule // liu_line_encoder
`default_nettype wire

// ==== design/liu_tx_device.sv ====
// Transmit front end of one line interface channel: sampling, encoding and pulse shaping.
// What this block does
// R01: Controller supplies 2.048 or 1.544 MHz clock; half periods of 9 and 12 pclk cycles give about 2.222 and 1.667 MHz.
// R02: Clock absent over 70 cycles raises interrupt.
// R03: Data sampled on selected clock edge.
// R04: Invert bit sets data active level.
// R05: Rail bit 0 uses single data input.
// R06: Rail bit 1 uses both rail inputs.
// R07: T1 single rail: B8ZS or AMI.
// R08: E1 single rail: HDB3 or AMI.
// R09: Dual rail bypasses the encoder.
// R10: Positive rail alone gives negative pulse.
// R11: E1 software picks codes 0000 or 0001.
// R12: J1 software picks code 0111.
// R13: Five T1 short haul templates.
// R14: Four build-out grades, 7.5 dB apart.
// R15: Top bits 11 select arbitrary waveform.
// R16: 64-byte RAM, interval and sample indexed.
// R17: Samples are 7-bit signed magnitude.
// R18: Twelve reference templates held in ROM.
// R19: Software indexes, sets direction, then executes.
// R20: Six-bit scale, default 100001, 3% step.
// R21: Summed overflow sets status and interrupt.
// R22: Scaling only in arbitrary waveform mode.
// R23: Standard bit 0 E1, 1 T1/J1.
// R24: Read completion loads data, clears execute.
//
// Implementation choice: register access over a simple strobe port (reg_wr, reg_rd).
`timescale 1ns/1ps
`default_nettype none
module liu_tx_device (
  input wire logic pclk, // Master clock.
  input wire logic presetn, // Asynchronous reset, active low.
  liu_tx_link_if.device link, // Transmit clock and data from the controller.
  input wire logic [7:0] reg_addr, // Register offset.
  input wire logic [7:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe, one cycle.
  input wire logic reg_rd, // Read strobe, one cycle.
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd.
  output logic signed [7:0] line_amplitude, // Shaped line sample, -63 to +63.
  output logic line_out_tip, // High while the line sample is positive.
  output logic line_out_ring, // High while the line sample is negative.
  output logic irq // Interrupt, active high.
);
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic clk_prev;
  logic [6:0] quiet_cycles;
  logic [7:0] tx_config_0;
  logic [3:0] pulse_select;
  logic [5:0] amplitude_scale;
  logic [7:0] waveform_ram_control;
  logic [6:0] sample_value;
  logic [7:0] interrupt_mask_1;
  logic [7:0] interrupt_status_1;
  logic line_standard_bit;
  logic [6:0] wave_ram [liu_tx_pkg::RAM_WORDS];
  logic dual_pos;
  logic dual_neg;
  logic enc_pos;
  logic enc_neg;
  logic [3:0] hist_pos;
  logic [3:0] hist_neg;
  logic [3:0] phase;
  logic signed [8:0] sum;
  logic signed [15:0] scaled;
  logic signed [7:0] next_amplitude;
  logic overflow;

  wire logic rail_mode_bit = tx_config_0[liu_tx_pkg::CFG_RAIL_BIT];
  wire logic encoder_select_bit = tx_config_0[liu_tx_pkg::CFG_ENCODER_BIT];
  wire logic tx_edge_select = tx_config_0[liu_tx_pkg::CFG_EDGE_BIT];
  wire logic tx_data_invert = tx_config_0[liu_tx_pkg::CFG_INVERT_BIT];
  wire logic arbitrary = pulse_select[3:2] == liu_tx_pkg::PULSE_ARB_PREFIX;
  wire logic [5:0] ram_addr = {waveform_ram_control[1:0], waveform_ram_control[5:2]};
  wire logic clk_rise = pin_sync[0] && !clk_prev;
  wire logic clk_fall = !pin_sync[0] && clk_prev;
  wire logic active_edge = tx_edge_select ? clk_fall : clk_rise;
  wire logic tx_single_rail_in = pin_sync[1] ^ tx_data_invert;
  wire logic tx_neg_data = pin_sync[2] ^ tx_data_invert;
  wire logic clock_lost = quiet_cycles == liu_tx_pkg::CLOCK_LOSS_CYCLES;
  wire logic status_read = reg_rd && reg_addr == liu_tx_pkg::OFF_INTERRUPT_STATUS_1;

  // Signed value of a 7-bit signed-magnitude sample.
  function automatic logic signed [8:0] sm_value(input logic [6:0] s);
    return s[6] ? -$signed({3'h0, s[5:0]}) : $signed({3'h0, s[5:0]});
  endfunction

  // Reference template sample: a flat top in the first interval, zero elsewhere.
  function automatic logic [6:0] template_sample(input logic [3:0] sel, input logic [1:0] ui,
                                                 input logic [3:0] ph);
    logic [6:0] s;
    s = 7'h00;
    if (ui == 2'h0 && ph >= liu_tx_pkg::TEMPLATE_FIRST && ph <= liu_tx_pkg::TEMPLATE_LAST)
      s = liu_tx_pkg::TEMPLATE_PEAK[sel];
    return s;
  endfunction

  // Two-flop synchronisers on the clock and both data pins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      clk_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= {link.tx_neg_rail_in, link.tx_pos_rail_in, link.tx_line_clock};
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[0];
    end
  end

  // Cycles since the last clock transition, held just past the loss limit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      quiet_cycles <= 7'h00;
    else if (clk_rise || clk_fall)
      quiet_cycles <= 7'h00;
    else if (quiet_cycles <= liu_tx_pkg::CLOCK_LOSS_CYCLES) // R02
      quiet_cycles <= quiet_cycles + 7'h01;
  end

  // Dual rail symbols go straight to the shaper on the active edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dual_pos <= 1'b0;
      dual_neg <= 1'b0;
    end
    else if (active_edge) // R03
    begin
      dual_pos <= rail_mode_bit && !tx_single_rail_in && tx_neg_data; // R06 R09 R10
      dual_neg <= rail_mode_bit && tx_single_rail_in && !tx_neg_data; // R10
    end
  end

  // Single rail data passes through the line encoder.
  liu_line_encoder u_encoder (
    .pclk(pclk),
    .presetn(presetn),
    .strobe(active_edge && !rail_mode_bit), // R05
    .bit_in(tx_single_rail_in), // R04
    .substitute(encoder_select_bit),
    .t1_mode(line_standard_bit), // R23
    .pulse_pos(enc_pos),
    .pulse_neg(enc_neg)
  );

  // Symbol history over four intervals and the sub-phase within the current one.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hist_pos <= 4'h0;
      hist_neg <= 4'h0;
      phase <= 4'h0;
    end
    else if (active_edge)
    begin
      hist_pos <= {hist_pos[2:0], rail_mode_bit ? dual_pos : enc_pos}; // R09
      hist_neg <= {hist_neg[2:0], rail_mode_bit ? dual_neg : enc_neg};
      phase <= 4'h0;
    end
    else if (phase != liu_tx_pkg::PHASE_LAST)
      phase <= phase + 4'h1;
  end

  // Sum overlapping pulses from RAM or ROM, scale in arbitrary mode, and clip.
  always_comb
  begin
    sum = 9'sh000;
    for (int k = 0; k < liu_tx_pkg::UI_COUNT; k++)
    begin
      logic [6:0] s;
      s = arbitrary ? wave_ram[{2'(k), phase}] // R15 R16
                    : template_sample(pulse_select, 2'(k), phase); // R13 R14 R18
      if (hist_pos[k])
        sum = sum + sm_value(s); // R17
      else if (hist_neg[k])
        sum = sum - sm_value(s);
    end
    scaled = 16'(sum);
    if (arbitrary) // R22
      scaled = 16'(sum * $signed({1'b0, amplitude_scale}) /
                    $signed({1'b0, liu_tx_pkg::SCALE_DEFAULT})); // R20
    overflow = scaled > 16'sd63 || scaled < -16'sd63; // R21
    if (scaled > 16'sd63)
      next_amplitude = 8'sd63;
    else if (scaled < -16'sd63)
      next_amplitude = -8'sd63;
    else
      next_amplitude = 8'(scaled);
  end

  // Registered line outputs.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_amplitude <= 8'sh00;
      line_out_tip <= 1'b0;
      line_out_ring <= 1'b0;
    end
    else
    begin
      line_amplitude <= next_amplitude;
      line_out_tip <= next_amplitude > 8'sh00;
      line_out_ring <= next_amplitude < 8'sh00;
    end
  end

  // Software writes to configuration registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_config_0 <= 8'h00;
      pulse_select <= 4'h0;
      amplitude_scale <= liu_tx_pkg::SCALE_DEFAULT;
      interrupt_mask_1 <= 8'h00;
      line_standard_bit <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        liu_tx_pkg::OFF_TX_CONFIG_0: tx_config_0 <= {4'h0, reg_wdata[3:0]};
        liu_tx_pkg::OFF_TX_PULSE_SELECT: pulse_select <= reg_wdata[3:0];
        liu_tx_pkg::OFF_TX_AMPLITUDE_SCALE: amplitude_scale <= reg_wdata[5:0];
        liu_tx_pkg::OFF_INTERRUPT_MASK_1: interrupt_mask_1 <= {6'h00, reg_wdata[1:0]};
        liu_tx_pkg::OFF_GLOBAL_CONFIG: line_standard_bit <= reg_wdata[liu_tx_pkg::GCFG_STANDARD_BIT];
        default: ;
      endcase
    end
  end

  // Waveform RAM access: the execute bit runs one read or write, then clears itself.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      waveform_ram_control <= 8'h00;
      sample_value <= 7'h00;
    end
    else if (waveform_ram_control[liu_tx_pkg::RAM_EXEC_BIT]) // R19
    begin
      if (waveform_ram_control[liu_tx_pkg::RAM_DIR_BIT])
        sample_value <= wave_ram[ram_addr]; // R24
      waveform_ram_control[liu_tx_pkg::RAM_EXEC_BIT] <= 1'b0; // R24
    end
    else if (reg_wr && reg_addr == liu_tx_pkg::OFF_WAVEFORM_RAM_CONTROL)
      waveform_ram_control <= reg_wdata;
    else if (reg_wr && reg_addr == liu_tx_pkg::OFF_WAVEFORM_RAM_DATA)
      sample_value <= reg_wdata[6:0];
  end

  // RAM write port, taken while an execute with direction 0 is pending.
  always_ff @(posedge pclk)
  begin
    if (waveform_ram_control[liu_tx_pkg::RAM_EXEC_BIT] &&
        !waveform_ram_control[liu_tx_pkg::RAM_DIR_BIT])
      wave_ram[ram_addr] <= sample_value; // R16 R19
  end

  // Sticky events, cleared by a status read; a new event in that cycle still sets.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_status_1 <= 8'h00;
    else
    begin
      interrupt_status_1[7:2] <= 6'h00;
      interrupt_status_1[liu_tx_pkg::INT_CLOCK_LOSS_BIT] <= clock_lost ||
        (interrupt_status_1[liu_tx_pkg::INT_CLOCK_LOSS_BIT] && !status_read); // R02
      interrupt_status_1[liu_tx_pkg::INT_OVERFLOW_BIT] <= overflow ||
        (interrupt_status_1[liu_tx_pkg::INT_OVERFLOW_BIT] && !status_read); // R21
    end
  end

  // Interrupt output: any unmasked status bit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(interrupt_status_1 & interrupt_mask_1); // R02 R21
  end

  // Read data, one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        liu_tx_pkg::OFF_TX_CONFIG_0: reg_rdata <= tx_config_0;
        liu_tx_pkg::OFF_TX_PULSE_SELECT: reg_rdata <= {4'h0, pulse_select};
        liu_tx_pkg::OFF_TX_AMPLITUDE_SCALE: reg_rdata <= {2'h0, amplitude_scale};
        liu_tx_pkg::OFF_WAVEFORM_RAM_CONTROL: reg_rdata <= waveform_ram_control;
        liu_tx_pkg::OFF_WAVEFORM_RAM_DATA: reg_rdata <= {1'b0, sample_value};
        liu_tx_pkg::OFF_INTERRUPT_MASK_1: reg_rdata <= interrupt_mask_1;
        liu_tx_pkg::OFF_INTERRUPT_STATUS_1: reg_rdata <= interrupt_status_1;
        liu_tx_pkg::OFF_GLOBAL_CONFIG: reg_rdata <= {7'h00, line_standard_bit};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // liu_tx_device
`default_nettype wire

// ==== design/liu_tx_host.sv ====
// Framer-side controller: makes the transmit clock and shifts data bytes onto the link.
`timescale 1ns/1ps
`default_nettype none
module liu_tx_host (
  input wire logic pclk, // Master clock.
  input wire logic presetn, // Asynchronous reset, active low.
  liu_tx_link_if.host link, // Transmit clock and data to the line interface.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, 1 write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr // APB error, unmapped address.
);
  logic [4:0] control;
  logic [7:0] shift_pos;
  logic [7:0] shift_neg;
  logic [3:0] bits_left;
  logic [4:0] div_count;

  wire logic setup = psel && !penable;
  wire logic access_write = psel && penable && pready && pwrite;
  wire logic pending = bits_left != 4'h0;
  wire logic [4:0] half = control[liu_tx_pkg::HCTL_T1_BIT] ? liu_tx_pkg::T1_HALF
                                                           : liu_tx_pkg::E1_HALF; // R01
  wire logic toggle = control[liu_tx_pkg::HCTL_ENABLE_BIT] && div_count == half - 5'h1;
  wire logic launch = toggle && (!link.tx_line_clock == control[liu_tx_pkg::HCTL_RISE_BIT]);
  wire logic invert = control[liu_tx_pkg::HCTL_INVERT_BIT];

  // APB answer prepared in the setup cycle so the access cycle completes at once.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && paddr != liu_tx_pkg::OFF_HOST_CONTROL &&
                 paddr != liu_tx_pkg::OFF_HOST_DATA && paddr != liu_tx_pkg::OFF_HOST_STATUS;
      case (paddr)
        liu_tx_pkg::OFF_HOST_CONTROL: prdata <= {27'h0, control};
        liu_tx_pkg::OFF_HOST_STATUS: prdata <= {31'h0, pending};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      control <= 5'h00;
    else if (access_write && paddr == liu_tx_pkg::OFF_HOST_CONTROL)
      control <= pwdata[4:0];
  end

  // Clock divider: the link clock toggles every 9 or 12 pclk cycles, the selected rate's half period rounded down.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_count <= 5'h00;
      link.tx_line_clock <= 1'b0;
    end
    else if (!control[liu_tx_pkg::HCTL_ENABLE_BIT])
      div_count <= 5'h00;
    else if (toggle)
    begin
      div_count <= 5'h00;
      link.tx_line_clock <= !link.tx_line_clock; // R01
    end
    else
      div_count <= div_count + 5'h1;
  end

  // Data byte loads when idle; bits leave MSB first on the launch edge, spaces when empty.
  // A data write while idle wins over a coinciding launch; a data write while bits are pending is dropped.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_pos <= 8'h00;
      shift_neg <= 8'h00;
      bits_left <= 4'h0;
      link.tx_pos_rail_in <= 1'b0;
      link.tx_neg_rail_in <= 1'b0;
    end
    else if (access_write && paddr == liu_tx_pkg::OFF_HOST_DATA && !pending)
    begin
      shift_pos <= pwdata[7:0];
      shift_neg <= pwdata[15:8];
      bits_left <= 4'(liu_tx_pkg::LINK_BITS);
    end
    else if (launch)
    begin
      link.tx_pos_rail_in <= (pending && shift_pos[7]) ^ invert; // R05
      link.tx_neg_rail_in <= (pending && control[liu_tx_pkg::HCTL_DUAL_BIT] && shift_neg[7])
                             ^ invert; // R06
      shift_pos <= {shift_pos[6:0], 1'b0};
      shift_neg <= {shift_neg[6:0], 1'b0};
      if (pending)
        bits_left <= bits_left - 4'h1;
    end
  end
endmodule // liu_tx_host
`default_nettype wire

// ==== verification/liu_tx_link_monitor.sv ====
// Checker for the transmit link between the controller and the line interface.
`timescale 1ns/1ps
`default_nettype none
module liu_tx_link_monitor (
  input wire logic pclk, // Master clock.
  input wire logic presetn, // Reset, active low.
  input wire logic tx_line_clock, // Link clock.
  input wire logic tx_pos_rail_in, // Single or positive rail.
  input wire logic tx_neg_rail_in // Negative rail.
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A half period of the link clock lasts at least nine master cycles.
  sequence s_half_hold;
    $stable(tx_line_clock) [*8];
  endsequence
  property p_clock_half;
    $changed(tx_line_clock) |=> s_half_hold;
  endproperty
  a_clock_half: assert property (p_clock_half)
    else $error("Link clock half period too short.");
  // Data lines move only together with a link clock edge.
  property p_pos_launch;
    $changed(tx_pos_rail_in) |-> $changed(tx_line_clock);
  endproperty
  a_pos_launch: assert property (p_pos_launch)
    else $error("Positive rail moved away from a clock edge.");
  property p_neg_launch;
    $changed(tx_neg_rail_in) |-> $changed(tx_line_clock);
  endproperty
  a_neg_launch: assert property (p_neg_launch)
    else $error("Negative rail moved away from a clock edge.");
  // Each data bit holds for at least nine master cycles.
  sequence s_pos_hold;
    $stable(tx_pos_rail_in) [*8];
  endsequence
  sequence s_neg_hold;
    $stable(tx_neg_rail_in) [*8];
  endsequence
  property p_pos_hold;
    $changed(tx_pos_rail_in) |=> s_pos_hold;
  endproperty
  a_pos_hold: assert property (p_pos_hold)
    else $error("Positive rail bit too short.");
  property p_neg_hold;
    $changed(tx_neg_rail_in) |=> s_neg_hold;
  endproperty
  a_neg_hold: assert property (p_neg_hold)
    else $error("Negative rail bit too short.");
  // The bench launches on the rising clock edge, away from the falling sample edge.
  property p_launch_rise;
    $changed(tx_pos_rail_in) |-> $rose(tx_line_clock);
  endproperty
  a_launch_rise: assert property (p_launch_rise)
    else $error("Positive rail moved off the rising clock edge.");
endmodule // liu_tx_link_monitor
`default_nettype wire

// ==== verification/tb_liu_transmit_encode_shaper.sv ====
// Testbench joining the controller and the line interface across the link.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_liu_transmit_encode_shaper;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] paddr = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic [31:0] pwdata = 32'h0, prdata, pv;
  logic pready, pslverr, tip, ring, irq, seen_tip;
  logic signed [7:0] amp;
  int fails = 0, checked = 0, k;
  logic [7:0] rows [5][3] = '{'{8'h02, 8'h06, 8'h06}, '{8'h03, 8'h0c, 8'h0c},
    '{8'h04, 8'h22, 8'h22}, '{8'h12, 8'h01, 8'h01}, '{8'h30, 8'h5a, 8'h00}};
  liu_tx_link_if link ();
  liu_tx_host liu_tx_host_inst (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  liu_tx_device liu_tx_device_inst (.pclk(pclk), .presetn(presetn), .link(link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_amplitude(amp), .line_out_tip(tip),
    .line_out_ring(ring), .irq(irq));
  liu_tx_link_monitor liu_tx_link_monitor_inst (.pclk(pclk), .presetn(presetn),
    .tx_line_clock(link.tx_line_clock), .tx_pos_rail_in(link.tx_pos_rail_in),
    .tx_neg_rail_in(link.tx_neg_rail_in));
  // Clock at 40 MHz.
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One device register write, one cycle strobe.
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge pclk);
    reg_wr <= 1'b0;
  endtask
  // One device register read; data settles after the taking edge.
  task automatic drd(input logic [7:0] a);
    @(posedge pclk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge pclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // One APB transfer that waits for pready under a bound.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin fails++; final_report(); end
    pv = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Main sequence: reset, register rows, RAM access, clock loss, dual rail.
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("irq", 1'b0, irq)
    drd(8'h04);
    `CHK("scale_reset", 8'h21, v)
    for (int i = 0; i < 5; i++)
    begin
      dwr(rows[i][0], rows[i][1]);
      drd(rows[i][0]);
      `CHK("reg_row", rows[i][2], v)
    end
    dwr(8'h03, 8'h07);
    drd(8'h03);
    `CHK("j1_pulse", 8'h07, v)
    dwr(8'h06, 8'h3f);
    dwr(8'h05, 8'h95);
    repeat (3) @(posedge pclk);
    dwr(8'h06, 8'h00);
    dwr(8'h05, 8'hd5);
    repeat (2) @(posedge pclk);
    drd(8'h05);
    `CHK("ram_exec", 1'b0, v[7])
    drd(8'h06);
    `CHK("ram_sample", 8'h3f, v)
    repeat (80) @(posedge pclk);
    `CHK("clock_loss_irq", 1'b1, irq)
    drd(8'h17);
    `CHK("clock_loss_status", 1'b1, v[0])
    drd(8'h17);
    `CHK("status_cleared", 1'b0, v[0])
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("apb_unmapped", 1'b1, pslverr)
    dwr(8'h12, 8'h00);
    dwr(8'h40, 8'h00);
    dwr(8'h03, 8'h00);
    dwr(8'h02, 8'h06);
    apb(1'b1, 8'h00, 32'h0000000d);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("apb_control", 32'h0000000d, pv)
    apb(1'b1, 8'h04, 32'h00000080);
    seen_tip = 1'b0;
    k = 0;
    do begin @(negedge pclk); k++; seen_tip |= tip; end while (ring !== 1'b1 && k < 2000);
    `CHK("dual_neg_pulse", 1'b1, ring)
    `CHK("dual_no_tip", 1'b0, seen_tip)
    `CHK("dual_amplitude", 8'(-$signed({1'b0, liu_tx_pkg::TEMPLATE_PEAK[0]})), amp)
    final_report();
  end
endmodule // tb_liu_transmit_encode_shaper
`default_nettype wire
